// File: rtl/crcri_pkg.sv
/*
 * Shared constants and types for the CRC register interface: register
 * addresses, control field positions, overlay codes, reset values, the
 * register bus request carrier and the engine state encoding.
 * Assumes a single clock domain and a master that never needs a wait state.
 */
// Contract
// R1 - The two-bit overlay select routes the shared address to result for 11 and 00, polynomial for 10 and shifter for 01.
// R2 - A shift-direction bit of 1 shifts right least significant bit first, 0 shifts left most significant bit first.
// R3 - The read-only full flag in bit 0 reads 1 while the data input holds unconsumed data and 0 once it moved into the shifter.
// R4 - The polynomial length minus one sits in bits 4:0 of the polynomial length control register.
// R5 - The data word length minus one sits in bits 4:0 of the word length control register.
// R6 - The data input is a readable and writable 32-bit value of four bytes, cleared to zero on reset.
// R7 - Result, shifter and feedback polynomial share one address and only the selected one is reachable.
// R8 - Busy reads 1 while shifting is in progress or pending and 0 only when all bits are in and the path is empty.
// R9 - A software or scanner write to the data input sets full, and the free shifter consumes it and clears full.
package crcri_pkg;

    // Register addresses on the plain register port.
    localparam logic [11:0] DATA_INPUT_ADDR     = 12'h034e;
    localparam logic [11:0] RESULT_OVERLAY_ADDR = 12'h0352;
    localparam logic [11:0] MAIN_CONTROL_ADDR   = 12'h0356;
    localparam logic [11:0] POLY_LEN_ADDR       = 12'h0357;
    localparam logic [11:0] WORD_LEN_ADDR       = 12'h0358;

    // Main control field positions, and the top bit of both length fields.
    localparam int ENABLE_BIT    = 7;
    localparam int GO_BIT        = 6;
    localparam int BUSY_BIT      = 5;
    localparam int ACCM_BIT      = 4;
    localparam int SETUP_HI_BIT  = 3;
    localparam int SETUP_LO_BIT  = 2;
    localparam int SHIFT_DIR_BIT = 1;
    localparam int FULL_BIT      = 0;
    localparam int LEN_HI_BIT    = 4;

    // Overlay select codes.
    localparam logic [1:0] OVL_RESULT_HI = 2'h3;
    localparam logic [1:0] OVL_POLY      = 2'h2;
    localparam logic [1:0] OVL_SHIFT     = 2'h1;
    localparam logic [1:0] OVL_RESULT_LO = 2'h0;

    // Reset values and sizes.
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [4:0]  LEN_RESET  = 5'h00;
    localparam logic [31:0] ALL_ONES   = 32'hffff_ffff;
    localparam logic [4:0]  MAX_INDEX  = 5'h1f;
    localparam int          FIFO_DEPTH = 16;
    localparam int          WORD_WIDTH = 32;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } crcri_bus_req_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } crcri_state_type;

    typedef struct packed {
        logic            enable;
        logic            go;
        logic            accm;
        logic [1:0]      setup;
        logic            shift_direction;
        logic            full;
        logic [4:0]      poly_length_minus_one;
        logic [4:0]      word_length_minus_one;
        logic [31:0]     data_input;
        logic [31:0]     crc_result;
        logic [31:0]     feedback_polynomial;
        logic [31:0]     shifter_view;
        logic [4:0]      bit_count;
        crcri_state_type state;
        logic [31:0]     rdata;
    } crcri_regs_type;

endpackage

// File: rtl/crcri_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes both sides run on the same clock; full and empty are exact.
 */
`timescale 1ns/10ps
module crcri_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
    } crcri_fifo_state_type;

    crcri_fifo_state_type r;
    crcri_fifo_state_type next_r;
    logic                 push;
    logic                 pop;

    // Handshakes come from the registered count, so a stalled drain stops the source only once DEPTH words are held.
    assign in_ready  = (r.count != (PW+1)'(DEPTH));
    assign out_valid = (r.count != '0);
    assign out_data  = r.mem[r.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointers wrap naturally; DEPTH is expected to be a power of two.
    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wr_ptr] = in_data;
            next_r.wr_ptr        = r.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_r.rd_ptr = r.rd_ptr + 1'b1;
        end
        case ({push, pop})
            2'b10:   next_r.count = r.count + 1'b1;
            2'b01:   next_r.count = r.count - 1'b1;
            default: next_r.count = r.count;
        endcase
    end

    // State register.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule

// File: rtl/crcri_top.sv
/*
 * CRC register interface: control registers, data input with full flag,
 * overlaid result, shifter and feedback polynomial registers, and a bit
 * serial shifter that folds data words into the accumulator.
 * Assumes a register master on the same clock that issues one-cycle
 * strobes, and a scanner on the same clock that honours scan_ready.
 */
`timescale 1ns/10ps
module crcri_top (
    input  wire logic                        clock,
    input  wire logic                        arst_n,
    input  wire crcri_pkg::crcri_bus_req_type bus_req,
    output logic [31:0]                      rdata,
    input  wire logic                        scan_valid,
    output logic                             scan_ready,
    input  wire logic [31:0]                 scan_data,
    output logic                             busy,
    output logic                             data_full
);
    import crcri_pkg::*;

    crcri_regs_type r;
    crcri_regs_type next_r;
    logic           fifo_valid;
    logic           fifo_ready;
    logic [31:0]    fifo_data;
    logic           sw_data_wr;
    logic           consume;
    logic           in_bit;
    logic           top_bit;
    logic           feedback;
    logic [31:0]    poly_mask;
    logic [31:0]    crc_shifted;
    logic [7:0]     main_control_value;

    // Scanner words queue here so a burst does not stall on a busy shifter.
    crcri_fifo #(
        .WIDTH (WORD_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_valid  (scan_valid),
        .in_ready  (scan_ready),
        .in_data   (scan_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // A software write to the data input takes priority over a queued word.
    assign sw_data_wr = bus_req.wr && (bus_req.addr == DATA_INPUT_ADDR);
    assign fifo_ready = !r.full && !sw_data_wr;

    // R9 shifter takes word
    assign consume = (r.state == ST_IDLE) && r.full && r.enable && r.go;

    // R8 busy covers pending
    assign busy      = r.full || (r.state == ST_SHIFT);
    assign data_full = r.full;
    assign rdata     = r.rdata;

    // Mask of the active polynomial bits; length field is length minus one.
    assign poly_mask = ALL_ONES >> (MAX_INDEX - r.poly_length_minus_one);

    // R2 direction picks bits
    always_comb begin
        if (r.shift_direction) begin
            in_bit  = r.shifter_view[0];
            top_bit = r.crc_result[0];
        end else begin
            in_bit  = r.shifter_view[r.word_length_minus_one];
            top_bit = r.crc_result[r.poly_length_minus_one];
        end
        feedback = (r.accm ? 1'b0 : in_bit) ^ top_bit;
        if (r.shift_direction) begin
            crc_shifted = r.crc_result >> 1;
        end else begin
            crc_shifted = (r.crc_result << 1) & poly_mask;
        end
        if (r.accm) begin
            crc_shifted[0] = r.shift_direction ? crc_shifted[0] : in_bit;
        end
    end

    // Main control image; busy and full are read-only status bits.
    always_comb begin
        main_control_value                = 8'h00;
        main_control_value[ENABLE_BIT]    = r.enable;
        main_control_value[GO_BIT]        = r.go;
        main_control_value[BUSY_BIT]      = busy;
        main_control_value[ACCM_BIT]      = r.accm;
        main_control_value[SETUP_HI_BIT]  = r.setup[1];
        main_control_value[SETUP_LO_BIT]  = r.setup[0];
        main_control_value[SHIFT_DIR_BIT] = r.shift_direction;
        // R3 full flag readback
        main_control_value[FULL_BIT]      = r.full;
    end

    // Next-state logic: shifting, consumption, queue drain, register access.
    always_comb begin
        next_r       = r;
        next_r.rdata = WORD_RESET;

        // One bit per clock enters the accumulator while shifting.
        case (r.state)
            ST_IDLE: begin
                next_r.state = ST_IDLE;
            end
            ST_SHIFT: begin
                next_r.crc_result = crc_shifted ^
                    (feedback ? (r.feedback_polynomial & poly_mask) : WORD_RESET);
                if (r.shift_direction) begin
                    next_r.shifter_view = r.shifter_view >> 1;
                end else begin
                    next_r.shifter_view = r.shifter_view << 1;
                end
                next_r.bit_count = r.bit_count - 1'b1;
                if (r.bit_count == LEN_RESET) begin
                    next_r.state = ST_IDLE;
                end
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase

        // R9 consume clears full
        if (consume) begin
            next_r.shifter_view = r.data_input;
            next_r.bit_count    = r.word_length_minus_one;
            next_r.state        = ST_SHIFT;
            next_r.full         = 1'b0;
        end

        // R9 scanner fills input
        if (fifo_valid && fifo_ready) begin
            next_r.data_input = fifo_data;
            next_r.full       = 1'b1;
        end

        // Register writes.
        if (bus_req.wr) begin
            case (bus_req.addr)
                DATA_INPUT_ADDR: begin
                    // R6 full word write
                    next_r.data_input = bus_req.wdata;
                    // R9 write sets full
                    next_r.full       = 1'b1;
                end
                RESULT_OVERLAY_ADDR: begin
                    // R1 overlay write routing
                    case (r.setup)
                        OVL_RESULT_HI: next_r.crc_result = bus_req.wdata;
                        OVL_POLY:      next_r.feedback_polynomial = bus_req.wdata;
                        OVL_SHIFT:     next_r.shifter_view = bus_req.wdata;
                        OVL_RESULT_LO: next_r.crc_result = bus_req.wdata;
                        default:       next_r.crc_result = bus_req.wdata;
                    endcase
                end
                MAIN_CONTROL_ADDR: begin
                    next_r.enable          = bus_req.wdata[ENABLE_BIT];
                    next_r.go              = bus_req.wdata[GO_BIT];
                    next_r.accm            = bus_req.wdata[ACCM_BIT];
                    next_r.setup           = bus_req.wdata[SETUP_HI_BIT:SETUP_LO_BIT];
                    next_r.shift_direction = bus_req.wdata[SHIFT_DIR_BIT];
                end
                POLY_LEN_ADDR: begin
                    // R4 poly length field
                    next_r.poly_length_minus_one = bus_req.wdata[LEN_HI_BIT:0];
                end
                WORD_LEN_ADDR: begin
                    // R5 word length field
                    next_r.word_length_minus_one = bus_req.wdata[LEN_HI_BIT:0];
                end
                default: begin
                    next_r.rdata = WORD_RESET;
                end
            endcase
        end

        // Clearing enable stops the shifter and drops the start request.
        if (!next_r.enable) begin
            next_r.go    = 1'b0;
            next_r.state = ST_IDLE;
        end

        // Reads answer on the next cycle only; unmapped addresses read zero.
        if (bus_req.rd) begin
            case (bus_req.addr)
                DATA_INPUT_ADDR: begin
                    // R6 data readback
                    next_r.rdata = r.data_input;
                end
                RESULT_OVERLAY_ADDR: begin
                    // R7 one view reachable
                    case (r.setup)
                        OVL_RESULT_HI: next_r.rdata = r.crc_result;
                        OVL_POLY:      next_r.rdata = r.feedback_polynomial;
                        OVL_SHIFT:     next_r.rdata = r.shifter_view;
                        OVL_RESULT_LO: next_r.rdata = r.crc_result;
                        default:       next_r.rdata = r.crc_result;
                    endcase
                end
                MAIN_CONTROL_ADDR: next_r.rdata = {24'h00_0000, main_control_value};
                POLY_LEN_ADDR:     next_r.rdata = {27'h000_0000, r.poly_length_minus_one};
                WORD_LEN_ADDR:     next_r.rdata = {27'h000_0000, r.word_length_minus_one};
                default:           next_r.rdata = WORD_RESET;
            endcase
        end
    end

    // State register; every control field has a defined reset value.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r                       <= '0;
            r.data_input            <= WORD_RESET;
            r.poly_length_minus_one <= LEN_RESET;
            r.word_length_minus_one <= LEN_RESET;
            r.state                 <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

endmodule

// File: dv/crcri_checker.sv
/*
 * Port checker for the CRC register interface.
 * Assumes it is bound to crcri_top and sees only that module's ports.
 */
`timescale 1ns/10ps
module crcri_checker (
    input wire logic                         clock,
    input wire logic                         arst_n,
    input wire crcri_pkg::crcri_bus_req_type bus_req,
    input wire logic [31:0]                  rdata,
    input wire logic                         scan_valid,
    input wire logic                         scan_ready,
    input wire logic [31:0]                  scan_data,
    input wire logic                         busy,
    input wire logic                         data_full
);
    import crcri_pkg::*;

    // One clock domain, so clock and reset are given once.
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Data, length and control read-backs span a write and the read that follows it with no gap.
    property p_full_set;
        bus_req.wr && bus_req.addr == DATA_INPUT_ADDR |=> data_full;
    endproperty
    a_full_set: assert property (p_full_set) else $error("full not set by data write");
    property p_busy_full;
        data_full |-> busy;
    endproperty
    a_busy_full: assert property (p_busy_full) else $error("busy low with word pending");
    property p_busy_fall;
        $fell(busy) |-> !data_full;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell with path full");
    property p_full_rb;
        bus_req.rd && bus_req.addr == MAIN_CONTROL_ADDR |=> rdata[FULL_BIT] == $past(data_full);
    endproperty
    a_full_rb: assert property (p_full_rb) else $error("full bit read back wrong");
    property p_data_rb;
        (bus_req.wr && bus_req.addr == DATA_INPUT_ADDR) ##1
        (bus_req.rd && bus_req.addr == DATA_INPUT_ADDR) |=> rdata == $past(bus_req.wdata, 2);
    endproperty
    a_data_rb: assert property (p_data_rb) else $error("data input read back wrong");
    property p_poly_length_minus_one_rb;
        (bus_req.wr && bus_req.addr == POLY_LEN_ADDR) ##1
        (bus_req.rd && bus_req.addr == POLY_LEN_ADDR)
        |=> rdata == {27'h000_0000, $past(bus_req.wdata[4:0], 2)};
    endproperty
    a_poly_length_minus_one_rb: assert property (p_poly_length_minus_one_rb) else $error("poly length read back wrong");
    property p_wlen_rb;
        (bus_req.wr && bus_req.addr == WORD_LEN_ADDR) ##1
        (bus_req.rd && bus_req.addr == WORD_LEN_ADDR)
        |=> rdata == {27'h000_0000, $past(bus_req.wdata[4:0], 2)};
    endproperty
    a_wlen_rb: assert property (p_wlen_rb) else $error("word length read back wrong");
    property p_dir_rb;
        (bus_req.wr && bus_req.addr == MAIN_CONTROL_ADDR) ##1
        (bus_req.rd && bus_req.addr == MAIN_CONTROL_ADDR)
        |=> rdata[4:1] == $past(bus_req.wdata[4:1], 2);
    endproperty
    a_dir_rb: assert property (p_dir_rb) else $error("control fields read back wrong");
    // Read data stand for one cycle only, so a stale word never looks like a fresh answer.
    property p_rdata_idle;
        !$past(bus_req.rd) |-> rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");

    // Main scenarios worth seeing at least once.
    c_busy_done: cover property ($fell(busy));
    c_scan_stall: cover property (scan_valid && !scan_ready);
    c_data_wr: cover property (bus_req.wr && bus_req.addr == DATA_INPUT_ADDR);
endmodule

bind crcri_top crcri_checker u_checker (
    .clock(clock), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
    .scan_valid(scan_valid), .scan_ready(scan_ready), .scan_data(scan_data),
    .busy(busy), .data_full(data_full)
);

// File: dv/crc_register_interface_tb_top.sv
/*
 * Self-checking bench for the CRC register interface.
 * Assumes the package, the design and the checker are compiled first.
 */
`timescale 1ns/10ps
module crc_register_interface_tb_top;
    import crcri_pkg::*;
    logic              clock;
    logic              arst_n;
    crcri_bus_req_type bus_req;
    logic [31:0]       rdata;
    logic              scan_valid;
    logic              scan_ready;
    logic [31:0]       scan_data;
    logic              busy;
    logic              data_full;
    int                failures;
    int                tests_run;
    int                n;
    logic              acc;
    logic [31:0]       got;
    logic [31:0]       dv;

    crcri_top DUT (
        .clock(clock), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
        .scan_valid(scan_valid), .scan_ready(scan_ready), .scan_data(scan_data),
        .busy(busy), .data_full(data_full)
    );

    // Clock at 50 MHz.
    always #10 clock = ~clock;

    // The strobe is left high so back-to-back writes never drive it twice in a step.
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge clock);
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        bus_req.wr   <= 1'b0;
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge clock);
        bus_req.rd <= 1'b0;
        @(negedge clock);
        got = rdata;
        @(posedge clock);
        check(what, exp, got);
    endtask

    // Bounded wait until the path is empty and shifting is over.
    task automatic wait_quiet();
        bus_req.wr <= 1'b0;
        repeat (2) @(posedge clock);
        for (int k = 0; k < 1000; k++) begin
            @(negedge clock);
            if (busy === 1'b0 && data_full === 1'b0) break;
        end
        @(posedge clock);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        final_report();
    end

    // Main test sequence.
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        bus_req = '0;
        scan_valid = 1'b0;
        scan_data = 32'h0000_0000;
        failures = 0;
        tests_run = 0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd_chk("data input", DATA_INPUT_ADDR, WORD_RESET);
        rd_chk("main control", MAIN_CONTROL_ADDR, WORD_RESET);
        rd_chk("unmapped", 12'h0350, WORD_RESET);
        $display("test reset values done");
        wr_reg(POLY_LEN_ADDR, 32'h0000_00ff);
        rd_chk("poly length", POLY_LEN_ADDR, 32'h0000_001f);
        wr_reg(WORD_LEN_ADDR, 32'h0000_00e7);
        rd_chk("word length", WORD_LEN_ADDR, 32'h0000_0007);
        wr_reg(MAIN_CONTROL_ADDR, 32'h0000_003f);
        rd_chk("main control", MAIN_CONTROL_ADDR, 32'h0000_001e);
        wr_reg(DATA_INPUT_ADDR, 32'h1234_5678);
        rd_chk("data input", DATA_INPUT_ADDR, 32'h1234_5678);
        check("full flag", 32'h0000_0001, 32'(data_full));
        rd_chk("main control", MAIN_CONTROL_ADDR, 32'h0000_003f);
        $display("test control and data done");
        // Codes 00 and 11 share the result, so the later write must win.
        for (int c = 0; c < 4; c++) begin
            wr_reg(MAIN_CONTROL_ADDR, 32'(c) << SETUP_LO_BIT);
            wr_reg(RESULT_OVERLAY_ADDR, 32'ha5a5_0000 + 32'(c));
        end
        for (int c = 0; c < 4; c++) begin
            wr_reg(MAIN_CONTROL_ADDR, 32'(c) << SETUP_LO_BIT);
            rd_chk("overlay", RESULT_OVERLAY_ADDR, 32'ha5a5_0000 + 32'(c == 0 ? 3 : c));
        end
        $display("test overlay done");
        // Drain the stale word, then one byte each way with an 8-bit polynomial.
        wr_reg(MAIN_CONTROL_ADDR, 32'h0000_00c0);
        wait_quiet();
        wr_reg(POLY_LEN_ADDR, 32'h0000_0007);
        for (int d = 0; d < 2; d++) begin
            dv = 32'(d) << SHIFT_DIR_BIT;
            wr_reg(MAIN_CONTROL_ADDR, 32'h0000_0008 | dv);
            wr_reg(RESULT_OVERLAY_ADDR, d ? 32'h0000_00e0 : 32'h0000_0007);
            wr_reg(MAIN_CONTROL_ADDR, dv);
            wr_reg(RESULT_OVERLAY_ADDR, WORD_RESET);
            wr_reg(MAIN_CONTROL_ADDR, 32'h0000_00c0 | dv);
            wr_reg(DATA_INPUT_ADDR, d ? 32'h0000_0001 : 32'h0000_0080);
            wait_quiet();
            rd_chk("crc result", RESULT_OVERLAY_ADDR, d ? 32'h0000_0091 : 32'h0000_0089);
            check("busy", 32'h0000_0000, 32'(busy));
        end
        $display("test crc shift done");
        // Scanner fills the buffer while the engine is stopped.
        wr_reg(MAIN_CONTROL_ADDR, WORD_RESET);
        bus_req.wr <= 1'b0;
        scan_valid <= 1'b1;
        scan_data <= 32'h0000_0100;
        n = 0;
        for (int k = 0; k < 24; k++) begin
            @(negedge clock);
            acc = scan_ready;
            @(posedge clock);
            if (acc) begin
                n++;
                scan_data <= 32'h0000_0100 + 32'(n);
            end
        end
        scan_valid <= 1'b0;
        check("scan words", 32'h0000_0011, 32'(n));
        rd_chk("first word", DATA_INPUT_ADDR, 32'h0000_0100);
        wr_reg(MAIN_CONTROL_ADDR, 32'h0000_00c0);
        wait_quiet();
        check("full flag", 32'h0000_0000, 32'(data_full));
        check("scan ready", 32'h0000_0001, 32'(scan_ready));
        rd_chk("last word", DATA_INPUT_ADDR, 32'h0000_0110);
        $display("test scanner done");
        final_report();
    end
endmodule
